// ### common/sfpi_pkg.sv
// Purpose: Shared constants and types for the serial flash pin front end.
// Assumes: Wishbone registers are 32-bit words at byte addresses below.
// Notes: Flash status layout keeps bits 1:0 as zero.
package sfpi_pkg;

    localparam int SFPI_ADDR_W = 8;
    localparam int SFPI_DATA_W = 32;
    localparam int SFPI_FIFO_WIDTH = 8;
    localparam int SFPI_FIFO_DEPTH = 32;

    // Register byte offsets
    localparam logic [7:0] SFPI_OFS_CTRL = 8'h00;
    localparam logic [7:0] SFPI_OFS_FSR = 8'h04;
    localparam logic [7:0] SFPI_OFS_TXDATA = 8'h08;
    localparam logic [7:0] SFPI_OFS_RXDATA = 8'h0c;
    localparam logic [7:0] SFPI_OFS_STATE = 8'h10;

    // Flash status field positions
    localparam int SFPI_FSR_BP_LSB = 2;
    localparam int SFPI_FSR_QE_POS = 6;
    localparam int SFPI_FSR_SWD_POS = 7;
    // Control field positions
    localparam int SFPI_CTRL_DIR_POS = 2;
    // Receive word valid flag position
    localparam int SFPI_RX_VLD_POS = 8;
    // Clear-on-one bit in the state word
    localparam int SFPI_ST_OVR_POS = 4;

    localparam logic [3:0] SFPI_BYTE_BITS = 4'h8;
    localparam logic [1:0] SFPI_SYNC_RST = 2'h3;

    typedef enum logic [1:0] {
        SFPI_LANE_SINGLE = 2'h0,
        SFPI_LANE_DUAL = 2'h1,
        SFPI_LANE_QUAD = 2'h2
    } sfpi_lanes_t;

    typedef struct packed {
        logic status_write_disable_bit;
        logic quad_enable_bit;
        logic [3:0] block_protect_bits;
    } sfpi_sr_t;

    typedef struct packed {
        logic dir_out;
        sfpi_lanes_t lanes;
    } sfpi_ctrl_t;

    localparam sfpi_sr_t SFPI_SR_RST = 6'h00;
    localparam sfpi_ctrl_t SFPI_CTRL_RST = 3'h0;
    localparam logic [7:0] SFPI_TX_RST = 8'hff;

endpackage

// ### rtl/sfpi_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two, at least 2.
// Notes: Head word is read straight from the storage flops.
`timescale 1ns/100ps
module sfpi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("sfpi_fifo: DEPTH must be a power of two of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    logic push;
    logic pop;

    assign out_valid_o = (wp_r != rp_r);
    assign in_ready_o = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_r[rp_r[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wp_r[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end

endmodule

// ### rtl/sfpi_core.sv
// Purpose: Pin front end of a serial flash: select, pause, lanes, status protection.
// Assumes: Pins and serial clock are asynchronous and sampled by clk_i.
// Notes: Serial clock must stay well below a quarter of clk_i.
`timescale 1ns/100ps
module sfpi_core #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [sfpi_pkg::SFPI_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [sfpi_pkg::SFPI_DATA_W-1:0] wb_dat_i,
    output logic [sfpi_pkg::SFPI_DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic select_n_i,
    input wire logic sck_i,
    input wire logic [3:0] data_line_i,
    output logic [3:0] data_line_o,
    output logic [3:0] data_line_oe_o,
    output logic standby_o
);
    import sfpi_pkg::*;

    // Pin synchronisers: stage 1 feeds stage 2 only
    logic [1:0] cs_ff_r;
    logic [1:0] sck_ff_r;
    logic [3:0] d_ff1_r;
    logic [3:0] d_s_r;
    logic sck_d_r;
    logic cs_d_r;
    logic [1:0] sync_fill_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cs_ff_r <= SFPI_SYNC_RST;
            sck_ff_r <= 2'h0;
            d_ff1_r <= 4'hf;
            d_s_r <= 4'hf;
            sck_d_r <= 1'b0;
            cs_d_r <= 1'b1;
            sync_fill_r <= 2'h0;
        end else begin
            cs_ff_r <= {cs_ff_r[0], select_n_i};
            sck_ff_r <= {sck_ff_r[0], sck_i};
            d_ff1_r <= data_line_i;
            d_s_r <= d_ff1_r;
            sck_d_r <= sck_ff_r[1];
            cs_d_r <= cs_ff_r[1];
            sync_fill_r <= {sync_fill_r[0], 1'b1};
        end
    end

    logic sel;
    logic cs_fall;
    logic rise;
    logic fall;
    assign sel = !cs_ff_r[1];
    assign cs_fall = sel && cs_d_r;
    assign rise = sck_ff_r[1] && !sck_d_r;
    assign fall = !sck_ff_r[1] && sck_d_r;

    sfpi_ctrl_t ctrl_r;
    sfpi_sr_t fsr_r;
    logic armed_r;
    logic seen_high_r;

    // Quad enable turns pins 2 and 3 into pure data lines
    logic hold_act;
    logic wp_low;
    assign hold_act = sel && !fsr_r.quad_enable_bit && !d_s_r[3];
    assign wp_low = !fsr_r.quad_enable_bit && !d_s_r[2];

    // Quad needs quad enable, otherwise lines 2/3 keep their pin roles
    sfpi_lanes_t lanes_eff;
    logic [3:0] step;
    always_comb begin
        lanes_eff = ctrl_r.lanes;
        if (ctrl_r.lanes == SFPI_LANE_QUAD && !fsr_r.quad_enable_bit) begin
            lanes_eff = SFPI_LANE_SINGLE;
        end
        unique case (lanes_eff)
            SFPI_LANE_DUAL: step = 4'h2;
            SFPI_LANE_QUAD: step = 4'h4;
            default: step = 4'h1;
        endcase
    end

    logic go;
    assign go = sel && armed_r && !hold_act;
    assign standby_o = !sel;

    // Arming needs select seen high at the pin, then a falling edge; the synchroniser reset value does not count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seen_high_r <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            if (!sel && sync_fill_r[1]) begin
                seen_high_r <= 1'b1;
            end
            if (cs_fall && seen_high_r) begin
                armed_r <= 1'b1;
            end
        end
    end

    // Receive path
    logic [7:0] rx_sh_r;
    logic [3:0] rx_cnt_r;
    logic [7:0] rx_sh_nxt;
    logic [3:0] rx_sum;
    logic rx_done;
    logic [7:0] pend_r;
    logic pend_vld_r;
    logic fifo_in_ready;
    logic overrun_r;

    always_comb begin
        unique case (lanes_eff)
            SFPI_LANE_DUAL: rx_sh_nxt = {rx_sh_r[5:0], d_s_r[1:0]};
            SFPI_LANE_QUAD: rx_sh_nxt = {rx_sh_r[3:0], d_s_r[3:0]};
            default: rx_sh_nxt = {rx_sh_r[6:0], d_s_r[0]};
        endcase
    end
    assign rx_sum = rx_cnt_r + step;
    assign rx_done = go && rise && !ctrl_r.dir_out && (rx_sum == SFPI_BYTE_BITS);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_sh_r <= 8'h00;
            rx_cnt_r <= 4'h0;
        end else if (!sel) begin
            rx_cnt_r <= 4'h0;
        end else if (go && rise && !ctrl_r.dir_out) begin
            rx_sh_r <= rx_sh_nxt;
            rx_cnt_r <= (rx_sum == SFPI_BYTE_BITS) ? 4'h0 : rx_sum;
        end
    end

    // One byte waits here while the FIFO is full; a second one is lost
    logic ovr_clr;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_r <= 8'h00;
            pend_vld_r <= 1'b0;
        end else if (rx_done && !(pend_vld_r && !fifo_in_ready)) begin
            pend_r <= rx_sh_nxt;
            pend_vld_r <= 1'b1;
        end else if (fifo_in_ready) begin
            pend_vld_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overrun_r <= 1'b0;
        end else if (rx_done && pend_vld_r && !fifo_in_ready) begin
            overrun_r <= 1'b1;
        end else if (ovr_clr) begin
            overrun_r <= 1'b0;
        end
    end

    // Transmit path
    logic [7:0] tx_hold_r;
    logic tx_full_r;
    logic [7:0] tx_sh_r;
    logic [3:0] tx_cnt_r;
    logic [3:0] tx_sum;
    logic rise_seen_r;
    logic tx_shift;
    logic tx_load;
    logic tx_wr;

    assign tx_sum = tx_cnt_r + step;
    // Mode 3 opens on a falling edge that must not shift the preload
    assign tx_shift = go && fall && rise_seen_r && ctrl_r.dir_out;
    assign tx_load = cs_fall || (tx_shift && tx_sum == SFPI_BYTE_BITS);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_sh_r <= SFPI_TX_RST;
            tx_cnt_r <= 4'h0;
            rise_seen_r <= 1'b0;
        end else if (!sel) begin
            tx_cnt_r <= 4'h0;
            rise_seen_r <= 1'b0;
        end else begin
            if (go && rise) begin
                rise_seen_r <= 1'b1;
            end
            if (tx_load) begin
                tx_sh_r <= tx_hold_r;
                tx_cnt_r <= 4'h0;
            end else if (tx_shift) begin
                tx_sh_r <= tx_sh_r << step;
                tx_cnt_r <= tx_sum;
            end
        end
    end

    // Software refill wins over a load in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_full_r <= 1'b0;
        end else if (tx_wr) begin
            tx_full_r <= 1'b1;
        end else if (tx_load) begin
            tx_full_r <= 1'b0;
        end
    end

    // Pin drive: data from flops, enables from synchronised state
    logic [3:0] dout_r;
    logic [3:0] oe_mask;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dout_r <= 4'h0;
        end else begin
            unique case (lanes_eff)
                SFPI_LANE_DUAL: dout_r <= {2'h0, tx_sh_r[7:6]};
                SFPI_LANE_QUAD: dout_r <= tx_sh_r[7:4];
                default: dout_r <= {2'h0, tx_sh_r[7], 1'b0};
            endcase
        end
    end

    always_comb begin
        unique case (lanes_eff)
            SFPI_LANE_DUAL: oe_mask = 4'h3;
            SFPI_LANE_QUAD: oe_mask = 4'hf;
            default: oe_mask = 4'h2;
        endcase
    end
    assign data_line_o = dout_r;
    assign data_line_oe_o = (go && ctrl_r.dir_out) ? oe_mask : 4'h0;

    // Wishbone slave: ack one cycle after the request, effects at the ack edge
    logic req;
    logic ack_r;
    logic done;
    logic [5:0] idx;
    logic [31:0] rdat;
    logic [31:0] rdat_r;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic rx_pop;
    logic fsr_wr;
    logic sr_locked;
    sfpi_sr_t fsr_in;

    assign req = wb_cyc_i && wb_stb_i;
    assign done = req && ack_r;
    assign idx = wb_adr_i[7:2];
    assign tx_wr = done && wb_we_i && wb_sel_i[0] && idx == SFPI_OFS_TXDATA[7:2];
    assign fsr_wr = done && wb_we_i && wb_sel_i[0] && idx == SFPI_OFS_FSR[7:2];
    assign ovr_clr = done && wb_we_i && wb_sel_i[0] && idx == SFPI_OFS_STATE[7:2]
        && wb_dat_i[SFPI_ST_OVR_POS];
    assign rx_pop = done && !wb_we_i && idx == SFPI_OFS_RXDATA[7:2];
    assign sr_locked = fsr_r.status_write_disable_bit && wp_low;
    assign fsr_in = {wb_dat_i[SFPI_FSR_SWD_POS], wb_dat_i[SFPI_FSR_QE_POS],
        wb_dat_i[SFPI_FSR_BP_LSB+3:SFPI_FSR_BP_LSB]};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && !ack_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= SFPI_CTRL_RST;
            tx_hold_r <= SFPI_TX_RST;
        end else if (done && wb_we_i && wb_sel_i[0]) begin
            if (idx == SFPI_OFS_CTRL[7:2]) begin
                ctrl_r <= wb_dat_i[SFPI_CTRL_DIR_POS:0];
            end
            if (idx == SFPI_OFS_TXDATA[7:2]) begin
                tx_hold_r <= wb_dat_i[7:0];
            end
        end
    end

    // Blocked writes are dropped silently
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fsr_r <= SFPI_SR_RST;
        end else if (fsr_wr && !sr_locked) begin
            fsr_r <= fsr_in;
        end
    end

    always_comb begin
        rdat = 32'h0;
        unique case (idx)
            SFPI_OFS_CTRL[7:2]: rdat = {29'h0, ctrl_r};
            SFPI_OFS_FSR[7:2]: rdat = {24'h0, fsr_r, 2'h0};
            SFPI_OFS_TXDATA[7:2]: rdat = {24'h0, tx_hold_r};
            SFPI_OFS_RXDATA[7:2]: rdat = {23'h0, fifo_out_valid, fifo_out_valid ? fifo_out_data : 8'h00};
            SFPI_OFS_STATE[7:2]: rdat = {25'h0, sr_locked, wp_low, overrun_r,
                tx_full_r, hold_act, armed_r, sel};
            default: rdat = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_r <= 32'h0;
        end else begin
            rdat_r <= rdat;
        end
    end
    assign wb_dat_o = rdat_r;
    assign wb_ack_o = ack_r;

    sfpi_fifo #(
        .WIDTH(SFPI_FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(pend_vld_r),
        .in_ready_o(fifo_in_ready),
        .in_data_i(pend_r),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(rx_pop),
        .out_data_o(fifo_out_data)
    );

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_float_desel: assert property ($past(select_n_i, 2) |-> data_line_oe_o == 4'h0)
        else $error("outputs driven while deselected");
    a_standby_level: assert property ($past(select_n_i, 2) |-> standby_o)
        else $error("standby indication wrong");
    a_no_arm_shift: assert property (!armed_r |-> !rx_done && data_line_oe_o == 4'h0)
        else $error("activity before first select edge");
    a_desel_ignore: assert property (!sel |=> rx_cnt_r == 4'h0 && !$rose(pend_vld_r))
        else $error("data accepted while deselected");
    a_rx_on_rise: assert property ($past(sel) && sel && rx_cnt_r != $past(rx_cnt_r) |-> $past(rise))
        else $error("receive count moved without rising edge");
    a_tx_on_fall: assert property ($past(sel) && sel && tx_cnt_r != $past(tx_cnt_r) |-> $past(fall))
        else $error("transmit count moved without falling edge");
    a_single_lane: assert property (lanes_eff == SFPI_LANE_SINGLE |-> !data_line_oe_o[0] && !data_line_oe_o[2])
        else $error("single mode drives the input line");
    a_quad_pins: assert property (data_line_oe_o[3] |-> fsr_r.quad_enable_bit && ctrl_r.lanes == SFPI_LANE_QUAD)
        else $error("line 3 driven outside quad");
    a_sr_protect: assert property (fsr_wr && sr_locked |=> fsr_r == $past(fsr_r))
        else $error("protected status bits changed");
    a_sr_open: assert property (fsr_wr && !fsr_r.status_write_disable_bit |=> fsr_r == $past(fsr_in))
        else $error("unprotected status write lost");
    a_qe_no_wp: assert property (fsr_r.quad_enable_bit |-> !wp_low && !hold_act)
        else $error("pin function active under quad enable");
    a_hold_float: assert property (hold_act |-> data_line_oe_o == 4'h0 && !rx_done)
        else $error("activity during pause");

    c_rx_byte: cover property (rx_done);
    c_sr_blocked: cover property (fsr_wr && sr_locked);
    c_quad_drive: cover property (data_line_oe_o == 4'hf);
    c_pause: cover property (hold_act ##1 !hold_act && sel);

endmodule

// ### bench/sfpi_master_model.sv
// Purpose: Behavioural serial bus master facing the flash pin front end.
// Assumes: Tasks are called from the bench; clk_i is the bench system clock.
// Notes: Device data is taken at the end of each high phase, since it holds until after the next fall.
`timescale 1ns/100ps
module sfpi_master_model (
    input wire logic clk_i,
    input wire logic [3:0] line_i,
    output logic select_n_o,
    output logic sck_o,
    output logic [3:0] line_o,
    output logic [3:0] line_oe_o
);
    logic [3:0] pins_r;
    logic m3_r;

    initial begin
        select_n_o = 1'b0;
        sck_o = 1'b0;
        line_o = 4'hc;
        line_oe_o = 4'hc;
        pins_r = 4'hc;
        m3_r = 1'b0;
    end

    // Only called while deselected when the clock idle level changes
    task automatic set_ctl(input logic wp, input logic pause, input logic m3);
        @(posedge clk_i);
        pins_r <= {pause, wp, 2'b00};
        line_o[3:2] <= {pause, wp};
        m3_r <= m3;
        sck_o <= m3;
    endtask

    task automatic sel(input logic lvl);
        @(posedge clk_i);
        select_n_o <= lvl;
        repeat (8) @(posedge clk_i);
    endtask

    task automatic frame(input int w, input logic tx, input logic use_sel, input logic [7:0] d,
                         output logic [7:0] q);
        logic [7:0] sh;
        logic [3:0] mask;
        logic [3:0] lanes;
        sh = d;
        q = 8'h00;
        mask = 4'((1 << w) - 1);
        lanes = (w == 1) ? 4'h2 : mask;
        @(posedge clk_i);
        if (use_sel) begin
            select_n_o <= 1'b0;
        end
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < 8 / w; i++) begin
            sck_o <= 1'b0;
            line_o <= (pins_r & ~mask) | (4'(sh >> (8 - w)) & mask);
            line_oe_o <= tx ? (4'hc & ~lanes) : (4'hc | mask);
            sh = sh << w;
            repeat (4) @(posedge clk_i);
            sck_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            q = (w == 1) ? {q[6:0], line_i[1]} : 8'((q << w) | (line_i & mask));
        end
        if (!m3_r) begin
            sck_o <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        line_o <= pins_r;
        line_oe_o <= 4'hc;
        if (use_sel) begin
            select_n_o <= 1'b1;
        end
        repeat (8) @(posedge clk_i);
    endtask
endmodule

// ### bench/sfpi_core_tb.sv
// Purpose: Self-checking bench for the flash pin front end over Wishbone and the serial pins.
// Assumes: Undriven data lines show the inverse of their last level, as there is no pull.
// Notes: Serial clock of 400 ns is made by the master model from the system clock.
`timescale 1ns/100ps
module sfpi_core_tb;
    import sfpi_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, select_n, sck, standby;
    logic [7:0] wb_adr_i, q;
    logic [3:0] wb_sel_i, line_w, last_r, dev_o, dev_oe, mdl_o, mdl_oe;
    logic [31:0] wb_dat_i, wb_dat_o, rv;
    logic [7:0] txv [3];
    int err_count, checks, cyc_cnt;

    sfpi_core #(.FIFO_DEPTH(SFPI_FIFO_DEPTH)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .select_n_i(select_n),
        .sck_i(sck), .data_line_i(line_w), .data_line_o(dev_o), .data_line_oe_o(dev_oe),
        .standby_o(standby));
    sfpi_master_model mdl_u (.clk_i(clk_i), .line_i(line_w), .select_n_o(select_n), .sck_o(sck),
        .line_o(mdl_o), .line_oe_o(mdl_oe));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i) last_r <= line_w;
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            line_w[k] = dev_oe[k] ? dev_o[k] : (mdl_oe[k] ? mdl_o[k] : ~last_r[k]);
        end
    end

    task automatic test_done();
        $display("err_count=%0d checks=%0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Whole run needs about 3900 cycles
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            err_count++;
            $display("[ERR] %0t timeout", $time);
            test_done();
        end
    end

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_pin(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t pin got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'hf;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // No cycle limit here; only the bench timeout ends a lost answer
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
        cmp_pin(4'(wb_ack_o), 4'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        cmp_reg(r, exp);
    endtask

    initial begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'hf;
        last_r = 4'h0;
        err_count = 0;
        checks = 0;
        cyc_cnt = 0;
        txv = '{8'h4b, 8'hd2, 8'h87};
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        mdl_u.frame(1, 1'b0, 1'b0, 8'h5a, q);
        rdc(SFPI_OFS_RXDATA, 32'h0);
        mdl_u.sel(1'b1);
        cmp_pin(dev_oe, 4'h0);
        cmp_pin(4'(standby), 4'h1);
        mdl_u.frame(1, 1'b0, 1'b0, 8'hc3, q);
        rdc(SFPI_OFS_RXDATA, 32'h0);
        mdl_u.frame(1, 1'b0, 1'b1, 8'ha5, q);
        rdc(SFPI_OFS_RXDATA, 32'h1a5);
        mdl_u.set_ctl(1'b1, 1'b1, 1'b1);
        mdl_u.frame(1, 1'b0, 1'b1, 8'h3c, q);
        mdl_u.set_ctl(1'b1, 1'b1, 1'b0);
        rdc(SFPI_OFS_RXDATA, 32'h13c);
        wr(SFPI_OFS_CTRL, 32'h1);
        mdl_u.frame(2, 1'b0, 1'b1, 8'h96, q);
        rdc(SFPI_OFS_RXDATA, 32'h196);
        wr(SFPI_OFS_FSR, 32'h40);
        wr(SFPI_OFS_CTRL, 32'h2);
        mdl_u.frame(4, 1'b0, 1'b1, 8'h1e, q);
        rdc(SFPI_OFS_RXDATA, 32'h11e);
        for (int m = 0; m < 3; m++) begin
            wr(SFPI_OFS_TXDATA, 32'(txv[m]));
            wr(SFPI_OFS_CTRL, 32'(4 + m));
            mdl_u.frame(1 << m, 1'b1, 1'b1, 8'h00, q);
            cmp_reg(32'(q), 32'(txv[m]));
        end
        wr(SFPI_OFS_FSR, 32'h0);
        wr(SFPI_OFS_CTRL, 32'h4);
        mdl_u.sel(1'b0);
        cmp_pin(dev_oe, 4'h2);
        cmp_pin(4'(standby), 4'h0);
        mdl_u.set_ctl(1'b1, 1'b0, 1'b0);
        repeat (6) @(posedge clk_i);
        cmp_pin(dev_oe, 4'h0);
        mdl_u.set_ctl(1'b1, 1'b1, 1'b0);
        repeat (6) @(posedge clk_i);
        cmp_pin(dev_oe, 4'h2);
        mdl_u.sel(1'b1);
        cmp_pin(dev_oe, 4'h0);
        cmp_pin(4'(standby), 4'h1);
        wr(SFPI_OFS_CTRL, 32'h0);
        wr(SFPI_OFS_FSR, 32'h94);
        rdc(SFPI_OFS_FSR, 32'h94);
        mdl_u.set_ctl(1'b0, 1'b1, 1'b0);
        repeat (6) @(posedge clk_i);
        wr(SFPI_OFS_FSR, 32'h0);
        rdc(SFPI_OFS_FSR, 32'h94);
        mdl_u.set_ctl(1'b1, 1'b1, 1'b0);
        repeat (6) @(posedge clk_i);
        wr(SFPI_OFS_FSR, 32'h0);
        rdc(SFPI_OFS_FSR, 32'h0);
        mdl_u.set_ctl(1'b0, 1'b1, 1'b0);
        repeat (6) @(posedge clk_i);
        wr(SFPI_OFS_FSR, 32'h3c);
        rdc(SFPI_OFS_FSR, 32'h3c);
        wr(SFPI_OFS_FSR, 32'hc0);
        wr(SFPI_OFS_FSR, 32'h40);
        rdc(SFPI_OFS_FSR, 32'h40);
        wr(SFPI_OFS_FSR, 32'h0);
        mdl_u.set_ctl(1'b1, 1'b1, 1'b0);
        // Fill FIFO and pending byte, then one more that must be lost
        for (int i = 0; i < 34; i++) begin
            mdl_u.frame(1, 1'b0, 1'b1, 8'(i), q);
        end
        wb(1'b0, SFPI_OFS_STATE, 32'h0, rv);
        cmp_reg(rv & (32'h1 << SFPI_ST_OVR_POS), 32'h1 << SFPI_ST_OVR_POS);
        for (int i = 0; i < 33; i++) begin
            rdc(SFPI_OFS_RXDATA, 32'h100 | 32'(i));
        end
        rdc(SFPI_OFS_RXDATA, 32'h0);
        wr(SFPI_OFS_STATE, 32'h1 << SFPI_ST_OVR_POS);
        wb(1'b0, SFPI_OFS_STATE, 32'h0, rv);
        cmp_reg(rv & (32'h1 << SFPI_ST_OVR_POS), 32'h0);
        wr(8'h14, 32'hff);
        rdc(8'h14, 32'h0);
        test_done();
    end
endmodule
